// >>> src/rsse_pkg.sv
// Purpose: shared constants and types for the rotate/set/sleep execution block
// Assumes: 16-bit instruction words, 8-bit data path, 4-phase instruction cycle
// Notes:   register offsets are byte addresses on the AHB-Lite slave
package rsse_pkg;

    // ------------------------------------------------------------
    // opcode matching
    // ------------------------------------------------------------
    localparam logic [5:0]  OPC_ROTR_HI   = 6'h10;      // 0100 00 da
    localparam logic [6:0]  OPC_SET_FILE_ALL_ONES_HI   = 7'h34;      // 0110 100 a
    localparam logic [15:0] OPC_SLEEP     = 16'h0003;
    localparam int          BIT_DEST      = 9;
    localparam int          BIT_ACCESS    = 8;
    localparam logic [7:0]  INDEX_LIMIT   = 8'h5F;      // highest indexed offset
    localparam logic [7:0]  ACCESS_SPLIT  = 8'h60;      // access bank low/high split
    localparam logic [3:0]  ACCESS_HIBANK = 4'hF;
    localparam logic [7:0]  ALL_ONES      = 8'hFF;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0]  OFF_INSTR  = 8'h00;         // write: issue instruction
    localparam logic [7:0]  OFF_CTRL   = 8'h04;         // bank select, extended enable
    localparam logic [7:0]  OFF_WREG   = 8'h08;         // working accumulator
    localparam logic [7:0]  OFF_STATUS = 8'h0C;         // flags, sleep, busy
    localparam logic [7:0]  OFF_WAKE   = 8'h10;         // write: wake event
    localparam logic [7:0]  OFF_FSR2   = 8'h14;         // index base for literal offset
    localparam logic [7:0]  OFF_WDT    = 8'h18;         // read: watchdog clear count
    localparam logic [7:0]  OFF_MEM    = 8'h80;         // data memory window base

    // status bit positions
    localparam int ST_ZERO  = 0;
    localparam int ST_NEG   = 1;
    localparam int ST_PD    = 2;
    localparam int ST_TO    = 3;
    localparam int ST_SLEEP = 4;
    localparam int ST_BUSY  = 5;

    // wake data: bit 0 = watchdog caused it
    localparam int WAKE_BY_WDT = 0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RSSE_Q1,
        RSSE_Q2,
        RSSE_Q3,
        RSSE_Q4
    } rsse_phase_e;

    typedef struct packed {
        logic       is_rot;
        logic       is_set;
        logic       is_sleep;
        logic       dest;
        logic [11:0] addr;
    } rsse_dec_s;

endpackage : rsse_pkg

// >>> src/rsse_mem.sv
// Purpose: data memory for the execution block, registered read
// Assumes: single port per direction, synchronous write
// Notes:   read data appear one clock after the address
`timescale 1ns/1ns
`default_nettype none
module rsse_mem #(
    parameter int AW = 12,
    parameter int DEPTH = 4096
) (
    input  wire logic          hclk,     // clock
    input  wire logic [AW-1:0] raddr,    // read address
    output logic      [7:0]    rdata,    // registered read data
    input  wire logic          we,       // write strobe
    input  wire logic [AW-1:0] waddr,    // write address
    input  wire logic [7:0]    wdata     // write data
);
    logic [7:0] mem [DEPTH];

    // synchronous read and write
    always_ff @(posedge hclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule : rsse_mem
`default_nettype wire

// >>> src/rsse_core.sv
// Purpose: executes rotate-right-no-carry, set-file and sleep over four phases
// Assumes: software issues instructions and reaches memory over AHB-Lite
// Notes:   memory window reads take one wait state once the core is idle; an instruction in flight stalls them longer
// Functional notes
// - rotate right no carry moves bit 0 into bit 7 and updates only negative and zero.
// - destination bit 0 writes the accumulator, 1 writes the source register.
// - access bit 0 uses the access bank, 1 uses the bank select register.
// - extended mode with access 0 and address up to 5Fh uses indexed literal offset.
// - set file writes FFh to the addressed register and leaves flags alone.
// - sleep clears power down and sets time out.
// - sleep clears the watchdog counter and postscaler.
// - sleep halts the oscillator, taking effect in the fourth phase.
// - a watchdog wake clears the time out bit.
`timescale 1ns/1ns
`default_nettype none
module rsse_core
    import rsse_pkg::*;
#(
    parameter int AW = 12
) (
    input  wire logic        hclk,       // clock
    input  wire logic        hresetn,    // async reset, active low
    input  wire logic        hsel,       // slave select
    input  wire logic [31:0] haddr,      // address
    input  wire logic [1:0]  htrans,     // transfer type
    input  wire logic        hwrite,     // write
    input  wire logic [2:0]  hsize,      // size
    input  wire logic [31:0] hwdata,     // write data
    input  wire logic        hready,     // bus ready
    output logic      [31:0] hrdata,     // read data
    output logic             hreadyout,  // slave ready
    output logic             hresp,      // always okay
    output logic             osc_stop,   // main oscillator halted
    output logic             wdt_clear   // watchdog and postscaler clear pulse
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rsse_phase_e phase_ff;
    logic        busy_ff;
    logic [15:0] instr_ff;
    rsse_dec_s   dec_ff;
    logic [7:0]  w_ff, bsr_ff, fsr2_ff, res_ff;
    logic        ext_ff, zero_ff, neg_ff, pd_ff, to_ff, sleep_ff, clr_ff;
    logic [7:0]  wdt_cnt_ff;
    logic        dph_ff, dwr_ff, rdwait_ff;
    logic [7:0]  daddr_ff;
    logic [7:0]  mem_rdata;
    logic        mem_we;
    logic [AW-1:0] mem_waddr, mem_raddr;
    logic [7:0]  mem_wdata;
    rsse_dec_s   dec_c;
    logic        take, bus_wr, bus_mem;

    assign take = hsel && hready && htrans[1];
    assign bus_mem = daddr_ff >= OFF_MEM;

    // ------------------------------------------------------------
    // decode and addressing
    // ------------------------------------------------------------
    // effective address: access bank, bank select or indexed offset
    always_comb begin
        dec_c = '0;
        dec_c.is_rot   = instr_ff[15:10] == OPC_ROTR_HI;
        dec_c.is_set   = instr_ff[15:9] == OPC_SET_FILE_ALL_ONES_HI;
        dec_c.is_sleep = instr_ff == OPC_SLEEP;
        dec_c.dest     = instr_ff[BIT_DEST];
        if (instr_ff[BIT_ACCESS]) begin
            dec_c.addr = {bsr_ff[3:0], instr_ff[7:0]};
        end else if (ext_ff && instr_ff[7:0] <= INDEX_LIMIT) begin
            dec_c.addr = {4'h0, fsr2_ff} + {4'h0, instr_ff[7:0]};
        end else if (instr_ff[7:0] >= ACCESS_SPLIT) begin
            dec_c.addr = {ACCESS_HIBANK, instr_ff[7:0]};
        end else begin
            dec_c.addr = {4'h0, instr_ff[7:0]};
        end
    end

    // ------------------------------------------------------------
    // four phase sequencer
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_ff <= RSSE_Q1;
            busy_ff  <= 1'b0;
            instr_ff <= 16'h0000;
            dec_ff   <= '0;
        end else if (!busy_ff) begin
            if (bus_wr && daddr_ff == OFF_INSTR && !sleep_ff) begin
                instr_ff <= hwdata[15:0];
                busy_ff  <= 1'b1;
                phase_ff <= RSSE_Q1;
            end
        end else begin
            case (phase_ff)
                RSSE_Q1: begin dec_ff <= dec_c; phase_ff <= RSSE_Q2; end
                RSSE_Q2: phase_ff <= RSSE_Q3;
                RSSE_Q3: phase_ff <= RSSE_Q4;
                RSSE_Q4: begin busy_ff <= 1'b0; phase_ff <= RSSE_Q1; end
                default: phase_ff <= RSSE_Q1;
            endcase
        end
    end

    // process data in Q3: rotate or all ones
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            res_ff <= 8'h00;
        end else if (busy_ff && phase_ff == RSSE_Q3) begin
            res_ff <= dec_ff.is_set ? ALL_ONES : {mem_rdata[0], mem_rdata[7:1]};
        end
    end

    // Q4 write back: accumulator and flags
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            w_ff    <= 8'h00;
            zero_ff <= 1'b0;
            neg_ff  <= 1'b0;
        end else if (busy_ff && phase_ff == RSSE_Q4 && dec_ff.is_rot) begin
            zero_ff <= res_ff == 8'h00;
            neg_ff  <= res_ff[7];
            if (!dec_ff.dest) begin
                w_ff <= res_ff;
            end
        end else if (bus_wr && daddr_ff == OFF_WREG) begin
            w_ff <= hwdata[7:0];
        end
    end

    // memory port: core write in Q4, else bus
    always_comb begin
        mem_raddr = busy_ff ? dec_ff.addr : AW'(daddr_ff - OFF_MEM); // bus reads use the latched data phase address
        mem_we    = 1'b0;
        mem_waddr = dec_ff.addr;
        mem_wdata = res_ff;
        if (busy_ff && phase_ff == RSSE_Q4 && (dec_ff.is_set || (dec_ff.is_rot && dec_ff.dest))) begin
            mem_we = 1'b1;
        end else if (bus_wr && bus_mem) begin
            mem_we    = 1'b1;
            mem_waddr = AW'(daddr_ff - OFF_MEM);
            mem_wdata = hwdata[7:0];
        end
    end

    rsse_mem #(.AW(AW), .DEPTH(1 << AW)) u_mem (
        .hclk  (hclk),
        .raddr (mem_raddr),
        .rdata (mem_rdata),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata)
    );

    // ------------------------------------------------------------
    // sleep, power status and watchdog clear
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pd_ff      <= 1'b1;
            to_ff      <= 1'b1;
            sleep_ff   <= 1'b0;
            clr_ff     <= 1'b0;
            wdt_cnt_ff <= 8'h00;
        end else begin
            clr_ff <= 1'b0;
            if (busy_ff && phase_ff == RSSE_Q4 && dec_ff.is_sleep) begin
                pd_ff      <= 1'b0;
                to_ff      <= 1'b1;
                clr_ff     <= 1'b1;
                wdt_cnt_ff <= wdt_cnt_ff + 8'h01;
                sleep_ff   <= 1'b1;
            end else if (bus_wr && daddr_ff == OFF_WAKE && sleep_ff) begin
                sleep_ff <= 1'b0;
                if (hwdata[WAKE_BY_WDT]) begin
                    to_ff <= 1'b0;
                end
            end
        end
    end

    assign osc_stop  = sleep_ff;
    assign wdt_clear = clr_ff;

    // ------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_ff   <= 1'b0;
            dwr_ff   <= 1'b0;
            daddr_ff <= 8'h00;
        end else if (hreadyout) begin
            dph_ff   <= take;
            dwr_ff   <= hwrite;
            daddr_ff <= haddr[7:0];
        end
    end

    assign bus_wr = dph_ff && dwr_ff && hreadyout;

    // control registers written by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bsr_ff  <= 8'h00;
            ext_ff  <= 1'b0;
            fsr2_ff <= 8'h00;
        end else if (bus_wr && daddr_ff == OFF_CTRL) begin
            bsr_ff <= hwdata[7:0];
            ext_ff <= hwdata[8];
        end else if (bus_wr && daddr_ff == OFF_FSR2) begin
            fsr2_ff <= hwdata[7:0];
        end
    end

    // memory reads wait one cycle; an instruction in flight stalls them
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdwait_ff <= 1'b0;
        end else begin
            // one wait cycle once the core is idle, so a read stalled by busy cannot hang the bus
            rdwait_ff <= dph_ff && bus_mem && !dwr_ff && !busy_ff && !rdwait_ff;
        end
    end

    assign hreadyout = !(dph_ff && ((bus_mem && (busy_ff || (!dwr_ff && !rdwait_ff)))
                         || (daddr_ff == OFF_INSTR && dwr_ff && busy_ff)));
    assign hresp = 1'b0;

    // read data mux
    always_comb begin
        hrdata = 32'h0000_0000;
        if (bus_mem) begin
            hrdata = {24'h00_0000, mem_rdata};
        end else begin
            case (daddr_ff)
                OFF_CTRL:   hrdata = {23'h00_0000, ext_ff, bsr_ff};
                OFF_WREG:   hrdata = {24'h00_0000, w_ff};
                OFF_STATUS: hrdata = {26'h000_0000, busy_ff, sleep_ff, to_ff, pd_ff, neg_ff, zero_ff};
                OFF_FSR2:   hrdata = {24'h00_0000, fsr2_ff};
                OFF_WDT:    hrdata = {24'h00_0000, wdt_cnt_ff};
                default:    hrdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_sleep_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        busy_ff && phase_ff == RSSE_Q4 && dec_ff.is_sleep |=> !pd_ff && to_ff && sleep_ff)
        else $error("sleep flags wrong");
    a_wdt_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        busy_ff && phase_ff == RSSE_Q4 && dec_ff.is_sleep |=> wdt_clear ##1 !wdt_clear)
        else $error("watchdog clear missing");
    a_sleep_phase: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(osc_stop) |-> $past(phase_ff) == RSSE_Q4)
        else $error("sleep outside fourth phase");
    a_wake_wdt: assert property (@(posedge hclk) disable iff (!hresetn)
        bus_wr && daddr_ff == OFF_WAKE && sleep_ff && hwdata[WAKE_BY_WDT] |=> !to_ff && !osc_stop)
        else $error("watchdog wake kept time out");
    a_four_phase: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(busy_ff) |-> busy_ff [*4] ##1 !busy_ff)
        else $error("instruction not four phases");
    a_rot_result: assert property (@(posedge hclk) disable iff (!hresetn)
        busy_ff && phase_ff == RSSE_Q3 && dec_ff.is_rot |=> res_ff == {$past(mem_rdata[0]), $past(mem_rdata[7:1])})
        else $error("rotate result wrong");
    a_rot_dest: assert property (@(posedge hclk) disable iff (!hresetn)
        busy_ff && phase_ff == RSSE_Q4 && dec_ff.is_rot |-> mem_we == dec_ff.dest)
        else $error("rotate destination wrong");
    a_set_file_all_ones_flags: assert property (@(posedge hclk) disable iff (!hresetn)
        busy_ff && phase_ff == RSSE_Q4 && dec_ff.is_set |-> mem_we && mem_wdata == ALL_ONES ##1 $stable(zero_ff) && $stable(neg_ff))
        else $error("set file wrong");
    a_bank_sel: assert property (@(posedge hclk) disable iff (!hresetn)
        busy_ff && phase_ff == RSSE_Q1 && instr_ff[BIT_ACCESS] |-> dec_c.addr[11:8] == bsr_ff[3:0])
        else $error("bank select ignored");
    a_indexed: assert property (@(posedge hclk) disable iff (!hresetn)
        busy_ff && phase_ff == RSSE_Q1 && !instr_ff[BIT_ACCESS] && ext_ff && instr_ff[7:0] <= INDEX_LIMIT
        |-> dec_c.addr == {4'h0, fsr2_ff} + {4'h0, instr_ff[7:0]})
        else $error("indexed offset wrong");
    c_rotate: cover property (@(posedge hclk) busy_ff && phase_ff == RSSE_Q4 && dec_ff.is_rot);
    c_set_file_all_ones:   cover property (@(posedge hclk) busy_ff && phase_ff == RSSE_Q4 && dec_ff.is_set);
    c_sleep:  cover property (@(posedge hclk) $rose(osc_stop));
    c_wake:   cover property (@(posedge hclk) $fell(to_ff));
endmodule : rsse_core
`default_nettype wire

// >>> bench/rotate_set_sleep_exec_test.sv
// Purpose: self-checking bench for the rotate/set/sleep execution block over AHB-Lite
// Assumes: hready fed back from hreadyout, one slave, single word transfers
// Notes:   reads queue their expectation, a monitor compares when the data phase ends
`timescale 1ns/1ns
`default_nettype none
module rotate_set_sleep_exec_test;
    import rsse_pkg::*;

    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    logic        hclk, hresetn, hsel, hwrite, rd_pend;
    logic [31:0] haddr, hwdata, hrdata, w_exp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, osc_stop, wdt_clear;
    logic [16:0] seed;
    logic [7:0]  v, r;
    logic [31:0] eq[$], mq[$];
    string       nq[$];
    int          miscompares, check_count, pulses;

    rsse_core dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .osc_stop(osc_stop), .wdt_clear(wdt_clear)
    );

    // clock at 100 MHz
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction : lfsr

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic summarize();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize

    // bounded wait for an edge with hready high
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            miscompares++;
            summarize();
        end
    endtask : wait_ready

    task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'b10;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus({24'h00_0000, a}, 1'b1, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string name);
        eq.push_back(e & m);
        mq.push_back(m);
        nq.push_back(name);
        bus({24'h00_0000, a}, 1'b0, 32'h0000_0000);
    endtask : rd

    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask : idle

    // rotate f with destination and access bits, then let the four phases finish
    task automatic rot(input logic d, input logic a, input logic [7:0] f);
        wr(OFF_INSTR, {16'h0000, 4'h4, 2'b00, d, a, f});
        idle(6);
    endtask : rot

    task automatic set_file_all_ones(input logic a, input logic [7:0] f);
        wr(OFF_INSTR, {16'h0000, 7'h34, a, f});
        idle(6);
    endtask : set_file_all_ones

    // ------------------------------------------------------------
    // monitor: compares read data against the oldest note
    // ------------------------------------------------------------
    always @(posedge hclk) begin
        if (wdt_clear === 1'b1) begin
            pulses++;
        end
        if (rd_pend && hreadyout === 1'b1) begin
            if (eq.size() == 0) begin
                chk("unexpected read", 32'h0000_0001, 32'h0000_0000);
            end else begin
                chk(nq.pop_front(), hrdata & mq.pop_front(), eq.pop_front());
            end
            chk("okay response", {31'h0, hresp}, 32'h0000_0000);
        end
        if (hreadyout === 1'b1) begin
            rd_pend <= hsel && htrans[1] && !hwrite;
        end
    end

    // global hang guard
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        summarize();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0000_0000; htrans = 2'b00; hwrite = 1'b0;
        hsize = 3'b010; hwdata = 32'h0000_0000; rd_pend = 1'b0; seed = 17'd72989;
        miscompares = 0; check_count = 0; pulses = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(OFF_STATUS, 32'h0000_000C, 32'h0000_003F, "status after reset");
        // rotate back into the file register, flags negative
        wr(OFF_MEM + 8'h10, 32'h0000_00D7);
        wr(OFF_INSTR, 32'h0000_4210);
        rd(OFF_STATUS, 32'h0000_0020, 32'h0000_0020, "busy during phases");
        idle(6);
        rd(OFF_STATUS, 32'h0000_0002, 32'h0000_0023, "flags after rotate");
        rd(OFF_MEM + 8'h10, 32'h0000_00EB, 32'h0000_00FF, "rotate to file");
        // rotate into accumulator through bank select, source kept
        rot(1'b0, 1'b1, 8'h10);
        rd(OFF_WREG, 32'h0000_00F5, 32'h0000_00FF, "rotate to accumulator");
        rd(OFF_MEM + 8'h10, 32'h0000_00EB, 32'h0000_00FF, "source unchanged");
        // zero result sets zero flag only
        wr(OFF_MEM + 8'h20, 32'h0000_0000);
        rot(1'b1, 1'b0, 8'h20);
        rd(OFF_STATUS, 32'h0000_0001, 32'h0000_0023, "zero flag");
        // random operands, both access bit values on bank 0
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = seed[7:0];
            r = {v[0], v[7:1]};
            wr(OFF_MEM + 8'h30, {24'h00_0000, v});
            rot(1'b0, i[0], 8'h30);
            rd(OFF_WREG, {24'h00_0000, r}, 32'h0000_00FF, "random rotate");
            rd(OFF_STATUS, {30'h0, r[7], r == 8'h00}, 32'h0000_0023, "random flags");
        end
        w_exp = {24'h00_0000, r};
        // set file through bank 1 misses bank 0, through bank 0 hits
        wr(OFF_MEM + 8'h40, 32'h0000_005A);
        wr(OFF_CTRL, 32'h0000_0001);
        set_file_all_ones(1'b1, 8'h40);
        rd(OFF_MEM + 8'h40, 32'h0000_005A, 32'h0000_00FF, "bank one selected");
        wr(OFF_CTRL, 32'h0000_0000);
        set_file_all_ones(1'b1, 8'h40);
        rd(OFF_MEM + 8'h40, 32'h0000_00FF, 32'h0000_00FF, "set file");
        rd(OFF_STATUS, {30'h0, r[7], r == 8'h00}, 32'h0000_0023, "set keeps flags");
        // indexed literal offset at the upper boundary
        wr(OFF_CTRL, 32'h0000_0100);
        wr(OFF_FSR2, 32'h0000_0020);
        wr(OFF_MEM + 8'h5F, 32'h0000_0011);
        set_file_all_ones(1'b0, 8'h5F);
        rd(OFF_MEM + 8'h7F, 32'h0000_00FF, 32'h0000_00FF, "indexed target");
        rd(OFF_MEM + 8'h5F, 32'h0000_0011, 32'h0000_00FF, "direct untouched");
        // above the index limit the upper access bank is used, not bank 0 and not the index
        wr(OFF_MEM + 8'h60, 32'h0000_0000);
        set_file_all_ones(1'b0, 8'h60);
        rot(1'b0, 1'b0, 8'h60);
        rd(OFF_WREG, 32'h0000_00FF, 32'h0000_00FF, "access bank high");
        rd(OFF_MEM + 8'h60, 32'h0000_0000, 32'h0000_00FF, "low bank untouched");
        w_exp = 32'h0000_00FF;
        wr(OFF_CTRL, 32'h0000_0000);
        // sleep entry, instructions ignored, plain wake keeps time-out
        wr(OFF_INSTR, {16'h0000, OPC_SLEEP});
        idle(6);
        chk("oscillator halted", {31'h0, osc_stop}, 32'h0000_0001);
        chk("watchdog clear pulses", pulses, 32'h0000_0001);
        rd(OFF_STATUS, 32'h0000_0018, 32'h0000_001C, "sleep status");
        rd(OFF_WDT, 32'h0000_0001, 32'h0000_00FF, "sleep entries");
        rot(1'b0, 1'b0, 8'h10);
        rd(OFF_WREG, w_exp, 32'h0000_00FF, "asleep ignores");
        wr(OFF_WAKE, 32'h0000_0000);
        idle(2);
        chk("oscillator running", {31'h0, osc_stop}, 32'h0000_0000);
        rd(OFF_STATUS, 32'h0000_0008, 32'h0000_0018, "plain wake");
        // watchdog wake clears time-out
        wr(OFF_INSTR, {16'h0000, OPC_SLEEP});
        idle(6);
        wr(OFF_WAKE, 32'h0000_0001);
        idle(2);
        rd(OFF_STATUS, 32'h0000_0000, 32'h0000_0018, "watchdog wake");
        rd(OFF_WDT, 32'h0000_0002, 32'h0000_00FF, "second entry");
        idle(4);
        chk("watchdog clear total", pulses, 32'h0000_0002);
        chk("notes drained", eq.size(), 32'h0000_0000);
        summarize();
    end
endmodule : rotate_set_sleep_exec_test
`default_nettype wire
